// ==== src/rsp_device.sv ====
// device end: serial slave, 128-byte register file and mode/block enables
// assumes link pins come from another domain and are synchronised here
`timescale 1ns/1ps
`include "rsp_consts.svh"
module rsp_device #(
   parameter int REG_COUNT = 128,
   parameter int ADDR_W = 7
) (
   input wire logic ref_clk,
   input wire logic rst,
   rsp_link_if.dev link,
   output rsp_pkg::rsp_mode_t mode,
   output logic spiPowerEn,
   output logic lfOscEn,
   output logic auxEn,
   output logic xtalEn,
   output logic synthEn,
   output logic paEn,
   output logic rxEn
);
   import rsp_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers; stage one feeds only stage two
   logic sclkS1, sclkS2, sclkPrev;
   logic selS1, selS2;
   logic sdiS1, sdiS2;
   logic sdnS1, sdnS2;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sclkS1 <= 1'b0;
         sclkS2 <= 1'b0;
         sclkPrev <= 1'b0;
         selS1 <= 1'b1;
         selS2 <= 1'b1;
         sdiS1 <= 1'b0;
         sdiS2 <= 1'b0;
         sdnS1 <= 1'b0;
         sdnS2 <= 1'b0;
      end else begin
         sclkS1 <= link.sclk;
         sclkS2 <= sclkS1;
         sclkPrev <= sclkS2;
         selS1 <= link.selectLow;
         selS2 <= selS1;
         sdiS1 <= link.serialIn;
         sdiS2 <= sdiS1;
         sdnS1 <= link.shutdownPin;
         sdnS2 <= sdnS1;
      end
   end

   logic sclkRise, sclkFall, portLive;
   // edges seen on the synchronised clock, so two ref_clk late
   assign sclkRise = sclkS2 & ~sclkPrev;
   assign sclkFall = ~sclkS2 & sclkPrev;
   assign portLive = ~selS2 & ~sdnS2;

   ////////////////////////////////////////////////////////////////////////
   // register file, one flop row per entry
   logic [7:0] regFile [REG_COUNT];
   logic wrEn, swReset;
   logic [ADDR_W-1:0] wrAddr;
   logic [7:0] wrData;
   logic wipe;

   // shutdown or software reset returns every register to its reset value
   assign wipe = rst | sdnS2 | swReset;

   genvar gi;
   generate
      for (gi = 0; gi < REG_COUNT; gi++) begin : g_reg
         localparam logic [ADDR_W-1:0] IDX = ADDR_W'(gi);
         localparam logic [7:0] RST_VAL = (IDX == `RSP_MODE_ADDR) ? `RSP_MODE_RESET : 8'h00;
         always_ff @(posedge ref_clk) begin
            if (wipe) begin
               regFile[gi] <= RST_VAL;
            end else if (wrEn && wrAddr == IDX) begin
               regFile[gi] <= wrData;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // serial shifter
   rsp_dev_state_t devState, next_devState;
   logic [2:0] bitCnt, next_bitCnt;
   logic [6:0] inShift, next_inShift;
   logic isWrite, next_isWrite;
   logic [ADDR_W-1:0] addr, next_addr;
   logic [7:0] outShift, next_outShift;
   logic next_serialOut, next_serialOutEn;
   logic serialOutQ, serialOutEnQ;
   logic next_wrEn, next_swReset;
   logic [ADDR_W-1:0] next_wrAddr;
   logic [7:0] next_wrData;
   logic [7:0] byteIn;
   logic [ADDR_W-1:0] headAddr, stepAddr;

   assign byteIn = {inShift, sdiS2};
   assign headAddr = byteIn[ADDR_W-1:0];
   assign stepAddr = addr + 7'h01;

   // next-state for the shifter and the write port
   always_comb begin
      next_devState = devState;
      next_bitCnt = bitCnt;
      next_inShift = inShift;
      next_isWrite = isWrite;
      next_addr = addr;
      next_outShift = outShift;
      next_serialOut = serialOutQ;
      next_serialOutEn = serialOutEnQ;
      next_wrEn = 1'b0;
      next_wrAddr = wrAddr;
      next_wrData = wrData;
      next_swReset = 1'b0;
      if (!portLive || swReset) begin
         // partial frames are dropped; the line goes back to the pullup
         next_devState = DS_HEAD;
         next_bitCnt = 3'h0;
         next_serialOut = 1'b1;
         next_serialOutEn = 1'b0;
      end else begin
         next_serialOutEn = 1'b1;
         if (sclkRise) begin
            next_inShift = {inShift[5:0], sdiS2};
            next_bitCnt = 3'(bitCnt + 3'h1);
            if (bitCnt == `RSP_BYTE_LAST) begin
               unique case (devState)
                  DS_HEAD: begin
                     next_isWrite = inShift[6];
                     next_addr = headAddr;
                     next_outShift = regFile[headAddr];
                     next_devState = DS_DATA;
                  end
                  DS_DATA: begin
                     if (isWrite) begin
                        next_wrEn = 1'b1;
                        next_wrAddr = addr;
                        next_wrData = byteIn;
                        next_swReset = (addr == `RSP_RESET_ADDR) && byteIn[`RSP_SWRESET_BIT];
                     end else begin
                        next_outShift = regFile[stepAddr];
                     end
                     next_addr = stepAddr;
                  end
               endcase
            end
         end else if (sclkFall && devState == DS_DATA && !isWrite) begin
            // serial_in is not looked at here: read data only flows out
            next_serialOut = outShift[7];
            next_outShift = {outShift[6:0], 1'b0};
         end
      end
   end

   // shifter registers; serial_out keeps each bit until the next falling edge or a deselect
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         devState <= DS_HEAD;
         bitCnt <= 3'h0;
         inShift <= 7'h00;
         isWrite <= 1'b0;
         addr <= 7'h00;
         outShift <= 8'h00;
         serialOutQ <= 1'b1;
         serialOutEnQ <= 1'b0;
         wrEn <= 1'b0;
         wrAddr <= 7'h00;
         wrData <= 8'h00;
         swReset <= 1'b0;
      end else begin
         devState <= next_devState;
         bitCnt <= next_bitCnt;
         inShift <= next_inShift;
         isWrite <= next_isWrite;
         addr <= next_addr;
         outShift <= next_outShift;
         serialOutQ <= next_serialOut;
         serialOutEnQ <= next_serialOutEn;
         wrEn <= next_wrEn;
         wrAddr <= next_wrAddr;
         wrData <= next_wrData;
         swReset <= next_swReset;
      end
   end

   assign link.serialOut = serialOutQ;
   assign link.serialOutEn = serialOutEnQ;

   ////////////////////////////////////////////////////////////////////////
   // operating mode and block enables from the mode register
   logic [7:0] modeReg;
   rsp_mode_t next_mode;
   logic next_spiPowerEn, next_lfOscEn, next_auxEn;
   logic next_xtalEn, next_synthEn, next_paEn, next_rxEn;

   assign modeReg = regFile[`RSP_MODE_ADDR];

   // highest requested mode wins; lower bits then only gate optional blocks
   always_comb begin
      if (sdnS2) begin
         next_mode = MD_SHUTDOWN;
      end else if (modeReg[`RSP_TXON_BIT]) begin
         next_mode = MD_TRANSMIT;
      end else if (modeReg[`RSP_RXON_BIT]) begin
         next_mode = MD_RECEIVE;
      end else if (modeReg[`RSP_PLLON_BIT]) begin
         next_mode = MD_TUNING;
      end else if (modeReg[`RSP_XTON_BIT]) begin
         next_mode = MD_READY;
      end else if (modeReg[`RSP_AUX_BIT]) begin
         next_mode = MD_SENSOR;
      end else if (modeReg[`RSP_ENWT_BIT]) begin
         next_mode = MD_SLEEP;
      end else begin
         next_mode = MD_STANDBY;
      end
      next_spiPowerEn = !sdnS2;
      // the 32 kHz and aux blocks are optional outside their own modes
      next_lfOscEn = !sdnS2 && modeReg[`RSP_ENWT_BIT];
      next_auxEn = !sdnS2 && modeReg[`RSP_AUX_BIT];
      next_xtalEn = next_mode inside {MD_READY, MD_TUNING, MD_TRANSMIT, MD_RECEIVE};
      next_synthEn = next_mode inside {MD_TUNING, MD_TRANSMIT, MD_RECEIVE};
      next_paEn = next_mode == MD_TRANSMIT;
      next_rxEn = next_mode == MD_RECEIVE;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         mode <= MD_READY;
         spiPowerEn <= 1'b1;
         lfOscEn <= 1'b0;
         auxEn <= 1'b0;
         xtalEn <= 1'b1;
         synthEn <= 1'b0;
         paEn <= 1'b0;
         rxEn <= 1'b0;
      end else begin
         mode <= next_mode;
         spiPowerEn <= next_spiPowerEn;
         lfOscEn <= next_lfOscEn;
         auxEn <= next_auxEn;
         xtalEn <= next_xtalEn;
         synthEn <= next_synthEn;
         paEn <= next_paEn;
         rxEn <= next_rxEn;
      end
   end
endmodule

// ==== src/rsp_consts.svh ====
// constants for the serial register port and its mode table
// assumes a 20 MHz ref_clk shared by both ends of the link
//
// Overview of operation
// - frame is direction bit, seven address, eight data
// - address picks one of 128 byte registers
// - direction one writes, zero reads
// - each byte captured after eight clock cycles
// - host keeps serial clock at most 10 MHz
// - read ignores serial_in after the address
// - read data shifted out on falling edges
// - last read bit held while selected; code puts out the next register's bit 7 on the final falling edge
// - deselect releases serial_out, pullup holds high
// - continued clocking auto-increments the address
// - burst writes capture every further byte
// - modes other than shutdown set by writes
// - shutdown kills port and wipes registers
// - port and registers live outside shutdown
// - each mode adds its own circuit blocks
// - optional blocks switch by configuration bits
// - resets and shutdown exit land in ready
// - shutdown pin high enters shutdown, no access
// - mode value zero standby, 40h sleep
`ifndef RSP_CONSTS_SVH
`define RSP_CONSTS_SVH

`define RSP_REF_CLK_MHZ 20
`define RSP_SCLK_HALF_NS 400
`define RSP_SCLK_HALF_CYC ((`RSP_SCLK_HALF_NS * `RSP_REF_CLK_MHZ + 999) / 1000)
`define RSP_SCLK_MAX_MHZ 10
`define RSP_BYTE_LAST 3'h7
`define RSP_FRAME_HEAD 4'h0
`define RSP_FRAME_WRAP 4'h8
`define RSP_FRAME_LAST 4'hf
`define RSP_MODE_ADDR 7'h07
`define RSP_RESET_ADDR 7'h08
`define RSP_MODE_RESET 8'h01
`define RSP_XTON_BIT 0
`define RSP_PLLON_BIT 1
`define RSP_RXON_BIT 2
`define RSP_TXON_BIT 3
`define RSP_AUX_BIT 5
`define RSP_ENWT_BIT 6
`define RSP_SWRESET_BIT 7

`endif

// ==== src/rsp_pkg.sv ====
// types shared by both ends of the serial register port
// assumes rsp_consts.svh for all numeric constants
package rsp_pkg;
   typedef enum logic [1:0] {
      DS_HEAD = 2'b01,
      DS_DATA = 2'b10
   } rsp_dev_state_t;

   typedef enum logic [5:0] {
      HS_IDLE = 6'b000001,
      HS_SETUP = 6'b000010,
      HS_LOW = 6'b000100,
      HS_HIGH = 6'b001000,
      HS_HOLD = 6'b010000,
      HS_GAP = 6'b100000
   } rsp_host_state_t;

   typedef enum logic [7:0] {
      MD_SHUTDOWN = 8'b00000001,
      MD_STANDBY = 8'b00000010,
      MD_SLEEP = 8'b00000100,
      MD_SENSOR = 8'b00001000,
      MD_READY = 8'b00010000,
      MD_TUNING = 8'b00100000,
      MD_TRANSMIT = 8'b01000000,
      MD_RECEIVE = 8'b10000000
   } rsp_mode_t;
endpackage

// ==== src/rsp_link_if.sv ====
// the four-wire serial link plus shutdown pin between host and device
// assumes both ends run on the same ref_clk; serial_out has a pullup
`timescale 1ns/1ps
interface rsp_link_if;
   logic sclk;
   logic selectLow;
   logic serialIn;
   logic shutdownPin;
   logic serialOut;
   logic serialOutEn;
   logic serialOutLine;

   // released line floats up through the pullup
   assign serialOutLine = serialOutEn ? serialOut : 1'b1;

   modport dev (
      input sclk,
      input selectLow,
      input serialIn,
      input shutdownPin,
      output serialOut,
      output serialOutEn
   );
   modport host (
      output sclk,
      output selectLow,
      output serialIn,
      output shutdownPin,
      input serialOutLine
   );
endinterface

// ==== src/rsp_host.sv ====
// host end: serial master issuing single and burst register accesses
// assumes serial_out arrives unsynchronised through the link interface
`timescale 1ns/1ps
`include "rsp_consts.svh"
module rsp_host #(
   parameter int HALF_CYC = `RSP_SCLK_HALF_CYC
) (
   input wire logic ref_clk,
   input wire logic rst,
   rsp_link_if.host link,
   input wire logic start,
   input wire logic reqWrite,
   input wire logic [6:0] reqAddr,
   input wire logic [7:0] reqData,
   input wire logic [6:0] burstExtra,
   input wire logic shutdownReq,
   output logic busy,
   output logic byteDone,
   output logic [7:0] rdData
);
   import rsp_pkg::*;

   // half period of 400 ns keeps the clock far below 10 MHz and leaves room
   // for both synchronisers on the read path
   localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);

   ////////////////////////////////////////////////////////////////////////
   // serial_out synchroniser
   logic sdoS1, sdoS2;
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sdoS1 <= 1'b1;
         sdoS2 <= 1'b1;
      end else begin
         sdoS1 <= link.serialOutLine;
         sdoS2 <= sdoS1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // master sequencer
   rsp_host_state_t st, next_st;
   logic [7:0] divCnt, next_divCnt;
   logic [3:0] bitCnt, next_bitCnt;
   logic [15:0] txShift, next_txShift;
   logic [7:0] rxShift, next_rxShift;
   logic [6:0] left, next_left;
   logic sclkQ, next_sclk, selQ, next_sel, sdiQ, next_sdi, sdnQ;
   logic next_busy, next_byteDone;
   logic [7:0] next_rdData;
   logic tick;

   assign tick = divCnt == HALF_LAST;

   always_comb begin
      next_st = st;
      next_divCnt = tick ? 8'h00 : 8'(divCnt + 8'h01);
      next_bitCnt = bitCnt;
      next_txShift = txShift;
      next_rxShift = rxShift;
      next_left = left;
      next_sclk = sclkQ;
      next_sel = selQ;
      next_sdi = sdiQ;
      next_byteDone = 1'b0;
      next_rdData = rdData;
      unique case (st)
         HS_IDLE: begin
            next_divCnt = 8'h00;
            // no access while the device is held in shutdown
            if (start && !sdnQ && !shutdownReq) begin
               next_txShift = {reqWrite, reqAddr, reqData};
               next_bitCnt = `RSP_FRAME_HEAD;
               next_left = burstExtra;
               next_sel = 1'b0;
               next_st = HS_SETUP;
            end
         end
         HS_SETUP: if (tick) begin
            next_sdi = txShift[15];
            next_st = HS_LOW;
         end
         HS_LOW: if (tick) begin
            next_sclk = 1'b1;
            next_rxShift = {rxShift[6:0], sdoS2};
            next_st = HS_HIGH;
         end
         HS_HIGH: if (tick) begin
            next_sclk = 1'b0;
            next_bitCnt = 4'(bitCnt + 4'h1);
            next_txShift = {txShift[14:0], 1'b0};
            next_sdi = txShift[14];
            next_st = HS_LOW;
            if (bitCnt == `RSP_FRAME_LAST) begin
               next_byteDone = 1'b1;
               next_rdData = rxShift;
               if (left != 7'h00) begin
                  // keep select low and send only data: address advances
                  next_left = 7'(left - 7'h01);
                  next_bitCnt = `RSP_FRAME_WRAP;
                  next_txShift = {reqData, 8'h00};
                  next_sdi = reqData[7];
               end else begin
                  next_st = HS_HOLD;
               end
            end
         end
         HS_HOLD: if (tick) begin
            next_sel = 1'b1;
            next_sdi = 1'b0;
            next_st = HS_GAP;
         end
         HS_GAP: if (tick) begin
            next_st = HS_IDLE;
         end
      endcase
      next_busy = next_st != HS_IDLE;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st <= HS_IDLE;
         divCnt <= 8'h00;
         bitCnt <= 4'h0;
         txShift <= 16'h0000;
         rxShift <= 8'h00;
         left <= 7'h00;
         sclkQ <= 1'b0;
         selQ <= 1'b1;
         sdiQ <= 1'b0;
         sdnQ <= 1'b0;
         busy <= 1'b0;
         byteDone <= 1'b0;
         rdData <= 8'h00;
      end else begin
         st <= next_st;
         divCnt <= next_divCnt;
         bitCnt <= next_bitCnt;
         txShift <= next_txShift;
         rxShift <= next_rxShift;
         left <= next_left;
         sclkQ <= next_sclk;
         selQ <= next_sel;
         sdiQ <= next_sdi;
         // shutdown pin only moves while no frame is running
         sdnQ <= (st == HS_IDLE) ? shutdownReq : sdnQ;
         busy <= next_busy;
         byteDone <= next_byteDone;
         rdData <= next_rdData;
      end
   end

   assign link.sclk = sclkQ;
   assign link.selectLow = selQ;
   assign link.serialIn = sdiQ;
   assign link.shutdownPin = sdnQ;
endmodule

// ==== verif/rsp_link_props.sv ====
// assertions on the serial link joining the host end to the device end
// assumes one ref_clk domain and instantiation beside the link interface
`timescale 1ns/1ps
module rsp_link_props (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic sclk,
   input wire logic selectLow,
   input wire logic serialIn,
   input wire logic shutdownPin,
   input wire logic serialOut,
   input wire logic serialOutEn,
   input wire logic serialOutLine
);
   logic [7:0] riseCount;
   logic [3:0] sinceFall;
   logic sclkPrev;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////////////
   // rising serial clocks per frame, and cycles since the last falling one
   always_ff @(posedge ref_clk) begin
      sclkPrev <= sclk;
      if (rst || selectLow) begin
         riseCount <= 8'h00;
      end else if (sclk && !sclkPrev) begin
         riseCount <= riseCount + 8'h01;
      end
      if (rst) begin
         sinceFall <= 4'hf;
      end else if (!sclk && sclkPrev) begin
         sinceFall <= 4'h0;
      end else if (sinceFall != 4'hf) begin
         sinceFall <= sinceFall + 4'h1; // saturates, long gaps need no count
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   a_sclk_rate: assert property ($rose(sclk) |-> sclk [*6])
      else $error("serial clock high phase too short");
   a_clock_selected: assert property (sclk |-> !selectLow)
      else $error("serial clock moved while deselected");
   a_frame_bytes: assert property ($rose(selectLow)
      |-> riseCount[2:0] == 3'h0 && riseCount >= 8'h10)
      else $error("frame not a whole number of bytes");
   a_release_pullup: assert property ($rose(selectLow) |-> ##[1:4] !serialOutEn)
      else $error("serial out not released after deselect");
   a_idle_high: assert property (selectLow && $past(selectLow, 5) |-> serialOutLine)
      else $error("serial out line not high while idle");
   a_drive_select: assert property ($fell(selectLow) && !shutdownPin
      |-> ##[1:4] serialOutEn)
      else $error("serial out not driven after select");
   a_out_timing: assert property (serialOutEn && $past(serialOutEn)
      && $changed(serialOut) |-> sinceFall <= 4'h5)
      else $error("serial out changed away from a falling clock");
   a_shutdown_quiet: assert property (shutdownPin && $past(shutdownPin, 4) |-> !serialOutEn)
      else $error("serial out driven in shutdown");
   a_no_access_down: assert property (shutdownPin |-> selectLow && !sclk)
      else $error("link accessed in shutdown");
endmodule

// ==== verif/radio_spi_register_port_test.sv ====
// testbench: host end and device end joined over one link, driven through the host
// assumes the design sources and rsp_consts.svh are compiled before this file
`timescale 1ns/1ps
`include "rsp_consts.svh"
module radio_spi_register_port_test;
   import rsp_pkg::*;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic start = 1'b0;
   logic reqWrite = 1'b0;
   logic [6:0] reqAddr = 7'h00;
   logic [7:0] reqData = 8'h00;
   logic [6:0] burstExtra = 7'h00;
   logic shutdownReq = 1'b0;
   logic hostRst = 1'b0;
   logic busy, byteDone;
   logic [7:0] rdData;
   rsp_mode_t mode;
   wire [6:0] enables;
   logic [15:0] wireIn, wireOut;
   logic [7:0] tx [0:7] = '{default: 8'h00};
   logic [7:0] got [0:7] = '{default: 8'h00};
   logic [7:0] mval [0:7] = '{8'h00, 8'h40, 8'h20, 8'h01, 8'h02, 8'h08, 8'h04, 8'h61};
   rsp_mode_t mexp [0:7] = '{MD_STANDBY, MD_SLEEP, MD_SENSOR, MD_READY, MD_TUNING,
      MD_TRANSMIT, MD_RECEIVE, MD_READY};
   logic [6:0] eexp [0:7] = '{7'h40, 7'h60, 7'h50, 7'h48, 7'h4c, 7'h4e, 7'h4d, 7'h78};
   int bad_count = 0;
   int checks_done = 0;
   rsp_link_if link ();
   ////////////////////////////////////////////////////////////////////////////////
   // both design ends on one link; the host alone can be reset to cut a frame
   rsp_host rsp_host_i (.ref_clk(ref_clk), .rst(rst | hostRst), .link(link), .start(start),
      .reqWrite(reqWrite), .reqAddr(reqAddr), .reqData(reqData), .burstExtra(burstExtra),
      .shutdownReq(shutdownReq), .busy(busy), .byteDone(byteDone), .rdData(rdData));
   rsp_device rsp_device_i (.ref_clk(ref_clk), .rst(rst), .link(link), .mode(mode),
      .spiPowerEn(enables[6]), .lfOscEn(enables[5]), .auxEn(enables[4]),
      .xtalEn(enables[3]), .synthEn(enables[2]), .paEn(enables[1]), .rxEn(enables[0]));
   // the checker sleeps through a host-only reset, whose cut frame is deliberate
   rsp_link_props rsp_link_props_i (.ref_clk(ref_clk), .rst(rst | hostRst), .sclk(link.sclk),
      .selectLow(link.selectLow), .serialIn(link.serialIn), .shutdownPin(link.shutdownPin),
      .serialOut(link.serialOut), .serialOutEn(link.serialOutEn),
      .serialOutLine(link.serialOutLine));
   ////////////////////////////////////////////////////////////////////////////////
   initial forever #25 ref_clk = ~ref_clk;
   // wire bits as seen at each rising serial clock
   always @(posedge link.sclk) begin
      wireIn <= {wireIn[14:0], link.serialIn};
      wireOut <= {wireOut[14:0], link.serialOutLine};
   end
   task automatic check_val(input logic [7:0] act, input logic [7:0] exp);
      checks_done++;
      if (act !== exp) begin
         bad_count++;
         $display("[FAIL] %0t value %h expected %h", $time, act, exp);
      end
   endtask
   task automatic check_mode(input rsp_mode_t act, input rsp_mode_t exp);
      checks_done++;
      if (act !== exp) begin
         bad_count++;
         $display("[FAIL] %0t mode %h expected %h", $time, act, exp);
      end
   endtask
   // one host frame of extra+1 bytes from tx; read bytes land in got
   task automatic xfer(input logic wr, input logic [6:0] addr, input int extra);
      int n;
      @(posedge ref_clk);
      #2;
      reqWrite = wr;
      reqAddr = addr;
      reqData = tx[0];
      burstExtra = 7'(extra);
      start = 1'b1;
      @(posedge ref_clk);
      #2;
      start = 1'b0;
      reqData = tx[1];
      for (int k = 0; k <= extra; k++) begin
         n = 0;
         while (byteDone !== 1'b1 && n < 2000) begin
            @(posedge ref_clk);
            #2;
            n++;
         end
         check_val({7'h00, byteDone}, 8'h01);
         got[k] = rdData;
         @(posedge ref_clk); // next byte is sampled at the byteDone edge, so change after it
         #2;
         reqData = tx[k + 2];
      end
      n = 0;
      while (busy !== 1'b0 && n < 2000) begin
         @(posedge ref_clk);
         #2;
         n++;
      end
      check_val({7'h00, busy}, 8'h00);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      check_mode(mode, MD_READY);
      check_val({1'b0, enables}, 8'h48);
      xfer(1'b0, `RSP_MODE_ADDR, 0);
      check_val(got[0], `RSP_MODE_RESET);
   endtask
   task automatic t_single();
      tx[0] = 8'h5a;
      xfer(1'b1, 7'h20, 0);
      check_val(wireIn[15:8], 8'ha0);
      check_val(wireIn[7:0], 8'h5a);
      check_val({6'h00, link.sclk, link.serialOutLine}, 8'h01);
      tx[0] = 8'hc3;
      xfer(1'b1, 7'h7f, 0);
      xfer(1'b0, 7'h20, 0);
      check_val(got[0], 8'h5a);
      check_val(wireIn[15:8], 8'h20);
      check_val(wireOut[7:0], 8'h5a);
      xfer(1'b0, 7'h7f, 0);
      check_val(got[0], 8'hc3);
   endtask
   task automatic t_burst();
      tx[0] = 8'h11;
      tx[1] = 8'h22;
      tx[2] = 8'h33;
      xfer(1'b1, 7'h7e, 2);
      xfer(1'b0, 7'h7e, 2);
      check_val(got[0], 8'h11);
      check_val(got[1], 8'h22);
      check_val(got[2], 8'h33);
      xfer(1'b0, 7'h00, 0);
      check_val(got[0], 8'h33);
   endtask
   task automatic t_modes();
      for (int i = 0; i < 8; i++) begin
         tx[0] = mval[i];
         xfer(1'b1, `RSP_MODE_ADDR, 0);
         repeat (8) @(posedge ref_clk);
         check_mode(mode, mexp[i]);
         check_val({1'b0, enables}, {1'b0, eexp[i]});
      end
   endtask
   task automatic t_swreset();
      tx[0] = 8'h77;
      xfer(1'b1, 7'h20, 0);
      tx[0] = 8'h80;
      xfer(1'b1, `RSP_RESET_ADDR, 0);
      xfer(1'b0, 7'h20, 0);
      check_val(got[0], 8'h00);
      xfer(1'b0, `RSP_MODE_ADDR, 0);
      check_val(got[0], `RSP_MODE_RESET);
      check_mode(mode, MD_READY);
      check_val({1'b0, enables}, 8'h48);
   endtask
   task automatic t_shutdown();
      tx[0] = 8'ha5;
      xfer(1'b1, 7'h30, 0);
      shutdownReq = 1'b1;
      repeat (10) @(posedge ref_clk);
      #2;
      check_mode(mode, MD_SHUTDOWN);
      check_val({1'b0, enables}, 8'h00);
      start = 1'b1;
      @(posedge ref_clk);
      #2;
      start = 1'b0;
      check_val({7'h00, busy}, 8'h00);
      shutdownReq = 1'b0;
      repeat (10) @(posedge ref_clk);
      check_mode(mode, MD_READY);
      xfer(1'b0, 7'h30, 0);
      check_val(got[0], 8'h00);
   endtask
   // host reset after five bits leaves a cut frame; the device must start afresh
   task automatic t_abort();
      @(posedge ref_clk);
      #2;
      reqWrite = 1'b1;
      reqAddr = 7'h11;
      reqData = 8'hc3;
      burstExtra = 7'h00;
      start = 1'b1;
      @(posedge ref_clk);
      #2;
      start = 1'b0;
      // fifth serial clock falls at cycle 88 after start, the sixth would rise at 96
      repeat (92) @(posedge ref_clk);
      #2;
      hostRst = 1'b1;
      repeat (3) @(posedge ref_clk);
      #2;
      hostRst = 1'b0;
      check_val({6'h00, link.selectLow, link.sclk}, 8'h02);
      tx[0] = 8'h3c;
      xfer(1'b1, 7'h11, 0);
      tx[0] = 8'hff;
      xfer(1'b0, 7'h11, 0);
      check_val(got[0], 8'h3c);
   endtask
   task automatic summarize();
      if (bad_count == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // watchdog: the whole sequence needs far fewer cycles than this
   initial begin
      repeat (60000) @(posedge ref_clk);
      bad_count++;
      summarize();
   end
   initial begin
      repeat (6) @(posedge ref_clk);
      #2;
      rst = 1'b0;
      t_reset();
      t_single();
      t_burst();
      t_modes();
      t_swreset();
      t_shutdown();
      t_abort();
      summarize();
   end
endmodule
